// ### rtl/oau_operand_address_unit.v
// Notes on behaviour
// - two independent generators give data and program addresses in one cycle
// - each generator holds four pointers, each updated on its own
// - indirect access issues pointer, then adds instruction-selected modify value
// - each pointer has a length giving circular-buffer post-modify
`timescale 1ns/100ps
`default_nettype none
`include "oau_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module oau_operand_address_unit #(
    parameter AW = `OAU_ADDR_W
) (
    input wire clock,
    input wire sys_rst,
    // generator 0: data-memory side
    input wire [1:0] dmOp,
    input wire [1:0] dmPtrSel,
    input wire [1:0] dmModSel,
    input wire [1:0] dmLoadTarget,
    input wire [1:0] dmLoadIndex,
    input wire [AW-1:0] dmLoadData,
    output reg [AW-1:0] dmAddr,
    output reg dmAddrValid,
    // generator 1: program-memory side
    input wire [1:0] pmOp,
    input wire [1:0] pmPtrSel,
    input wire [1:0] pmModSel,
    input wire [1:0] pmLoadTarget,
    input wire [1:0] pmLoadIndex,
    input wire [AW-1:0] pmLoadData,
    output reg [AW-1:0] programMemoryAddressBus,
    output reg pmAddrValid
);

    wire [AW-1:0] genAddr [0:1];
    wire genValid [0:1];
    wire [1:0] op [0:1];
    wire [1:0] ps [0:1];
    wire [1:0] ms [0:1];
    wire [1:0] lt [0:1];
    wire [1:0] li [0:1];
    wire [AW-1:0] ld [0:1];
    assign op[0] = dmOp;
    assign op[1] = pmOp;
    assign ps[0] = dmPtrSel;
    assign ps[1] = pmPtrSel;
    assign ms[0] = dmModSel;
    assign ms[1] = pmModSel;
    assign lt[0] = dmLoadTarget;
    assign lt[1] = pmLoadTarget;
    assign li[0] = dmLoadIndex;
    assign li[1] = pmLoadIndex;
    assign ld[0] = dmLoadData;
    assign ld[1] = pmLoadData;

    ////////////////////////////////////////////////////////////////////////////
    // both generators work in the same cycle, so dual fetch needs no arbitration
    genvar g;
    genvar e;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_unit
            wire [AW-1:0] ptrWord [0:`OAU_NUM_PTR-1];
            wire [AW-1:0] modWord [0:`OAU_NUM_PTR-1];
            wire [AW-1:0] lenWord [0:`OAU_NUM_PTR-1];
            wire [AW-1:0] baseWord [0:`OAU_NUM_PTR-1];

            wire isAccess;
            wire isLoad;
            wire loadPtr;
            wire loadMod;
            wire loadLen;
            wire loadBase;

            reg [AW-1:0] cur;
            reg [AW-1:0] m;
            reg [AW-1:0] l;
            reg [AW-1:0] b;
            reg [AW:0] sum;
            reg [AW-1:0] lin;
            reg [AW:0] endAddr;
            reg wrapLow;
            reg wrapHigh;
            reg [AW-1:0] next_ptr;

            // command decode; op code 3 matches nothing below and is ignored
            assign isAccess = (op[g] == `OAU_OP_ACCESS);
            assign isLoad = (op[g] == `OAU_OP_LOAD);
            assign loadPtr = isLoad && (lt[g] == `OAU_TGT_PTR);
            assign loadMod = isLoad && (lt[g] == `OAU_TGT_MOD);
            assign loadLen = isLoad && (lt[g] == `OAU_TGT_LEN);
            // a pointer load moves the base too, so a fresh buffer starts where it points
            assign loadBase = isLoad && (lt[g] == `OAU_TGT_BASE || lt[g] == `OAU_TGT_PTR);

            ////////////////////////////////////////////////////////////////////
            for (e = 0; e < `OAU_NUM_PTR; e = e + 1) begin : gen_entry
                localparam [31:0] IDX = e;
                reg [AW-1:0] pointer;
                reg [AW-1:0] modify;
                reg [AW-1:0] length;
                reg [AW-1:0] bufBase;
                wire stepHit;
                wire ptrLoadHit;
                wire modLoadHit;
                wire lenLoadHit;
                wire baseLoadHit;

                // an entry moves only when it is the one addressed, others keep their value
                assign stepHit = isAccess && (ps[g] == IDX[1:0]);
                assign ptrLoadHit = loadPtr && (li[g] == IDX[1:0]);
                assign modLoadHit = loadMod && (li[g] == IDX[1:0]);
                assign lenLoadHit = loadLen && (li[g] == IDX[1:0]);
                assign baseLoadHit = loadBase && (li[g] == IDX[1:0]);

                always @(posedge clock or posedge sys_rst) begin
                    if (sys_rst) begin
                        pointer <= `OAU_RST_VAL;
                    end else if (stepHit) begin
                        pointer <= next_ptr;
                    end else if (ptrLoadHit) begin
                        pointer <= ld[g];
                    end
                end

                // reset clears every length, so all buffers start out linear
                always @(posedge clock or posedge sys_rst) begin
                    if (sys_rst) begin
                        modify <= `OAU_RST_VAL;
                        length <= `OAU_RST_VAL;
                        bufBase <= `OAU_RST_VAL;
                    end else begin
                        if (modLoadHit) begin
                            modify <= ld[g];
                        end
                        if (lenLoadHit) begin
                            length <= ld[g];
                        end
                        if (baseLoadHit) begin
                            bufBase <= ld[g];
                        end
                    end
                end

                assign ptrWord[e] = pointer;
                assign modWord[e] = modify;
                assign lenWord[e] = length;
                assign baseWord[e] = bufBase;
            end

            ////////////////////////////////////////////////////////////////////
            // operand fetch: the selected pointer and the buffer it belongs to
            always @* begin
                cur = ptrWord[ps[g]];
                m = modWord[ms[g]];
                l = lenWord[ps[g]];
                b = baseWord[ps[g]];
            end

            // modify is two's complement, so the low bits of sum are the linear result
            always @* begin
                sum = {1'b0, cur} + {1'b0, m};
                lin = sum[AW-1:0];
                endAddr = {1'b0, b} + {1'b0, l};
            end

            // one wrap covers any modify no larger than the length; larger steps are not caught
            always @* begin
                wrapLow = 1'b0;
                wrapHigh = 1'b0;
                if (m[AW-1]) begin
                    // a negative step landing above the old pointer went below zero
                    wrapLow = (lin < b) || (lin > cur);
                end else begin
                    // the carry catches a step whose sum runs past the top of memory, even for a buffer that ends below it
                    wrapHigh = ({1'b0, lin} >= endAddr) || sum[AW];
                end
            end

            always @* begin
                next_ptr = lin;
                if (l != {AW{1'b0}}) begin
                    if (wrapLow) begin
                        next_ptr = lin + l;
                    end else if (wrapHigh) begin
                        next_ptr = lin - l;
                    end
                end
            end

            assign genAddr[g] = cur;
            assign genValid[g] = isAccess;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // the address holds between accesses; only the strobe marks a new one
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dmAddr <= `OAU_RST_VAL;
            dmAddrValid <= 1'b0;
        end else begin
            dmAddrValid <= genValid[0];
            if (genValid[0]) begin
                dmAddr <= genAddr[0];
            end
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            programMemoryAddressBus <= `OAU_RST_VAL;
            pmAddrValid <= 1'b0;
        end else begin
            pmAddrValid <= genValid[1];
            if (genValid[1]) begin
                programMemoryAddressBus <= genAddr[1];
            end
        end
    end

endmodule // oau_operand_address_unit
`default_nettype wire

// ### shared/oau_consts.vh
`ifndef OAU_CONSTS_VH
`define OAU_CONSTS_VH
`define OAU_ADDR_W 14
`define OAU_NUM_PTR 4
`define OAU_SEL_W 2
`define OAU_RST_VAL 14'h0000
`define OAU_OP_NONE 2'h0
`define OAU_OP_ACCESS 2'h1
`define OAU_OP_LOAD 2'h2
`define OAU_TGT_PTR 2'h0
`define OAU_TGT_MOD 2'h1
`define OAU_TGT_LEN 2'h2
`define OAU_TGT_BASE 2'h3
`endif

// ### tb/oau_chk.sv
`timescale 1ns/100ps
`default_nettype none
module oau_chk #(
    parameter int AW = 14
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [1:0] dmOp,
    input wire logic [1:0] pmOp,
    input wire logic [AW-1:0] dmAddr,
    input wire logic dmAddrValid,
    input wire logic [AW-1:0] programMemoryAddressBus,
    input wire logic pmAddrValid
);
default clocking @(posedge clock); endclocking
default disable iff (sys_rst);
a_dm_strobe: assert property (dmOp == 2'h1 |=> dmAddrValid)
    else $error("dm strobe");
a_dm_quiet: assert property (dmOp != 2'h1 |=> !dmAddrValid)
    else $error("dm extra");
a_dm_addr_hold: assert property (!dmAddrValid |-> $stable(dmAddr))
    else $error("dm moved");
a_pm_strobe: assert property (pmOp == 2'h1 |=> pmAddrValid)
    else $error("pm strobe");
a_dual_fetch: assert property (dmOp == 2'h1 && pmOp == 2'h1 |=> dmAddrValid && pmAddrValid)
    else $error("dual fetch");
a_pm_quiet: assert property (pmOp != 2'h1 |=> !pmAddrValid)
    else $error("pm extra");
a_pm_addr_hold: assert property (!pmAddrValid |-> $stable(programMemoryAddressBus))
    else $error("pm moved");
endmodule // oau_chk
bind oau_operand_address_unit oau_chk #(.AW(AW)) i_oau_chk (.clock(clock), .sys_rst(sys_rst),
    .dmOp(dmOp), .pmOp(pmOp), .dmAddr(dmAddr), .dmAddrValid(dmAddrValid),
    .programMemoryAddressBus(programMemoryAddressBus), .pmAddrValid(pmAddrValid));
`default_nettype wire

// ### tb/oau_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// memory side only counts strobes, so a lost or doubled fetch shows
module oau_mem_model (
    input wire clock,
    input wire valid,
    output logic [7:0] fetches = 8'h00
);
always @(posedge clock) if (valid) fetches <= fetches + 8'h01;
endmodule // oau_mem_model
`default_nettype wire

// ### tb/oau_operand_address_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module oau_operand_address_unit_tb_top;
logic clock = 1'b0;
logic sys_rst = 1'b1;
logic [1:0] op = 2'h0, ptr = 2'h0, md = 2'h0, tgt = 2'h0, idx = 2'h0;
logic [1:0] pOp = 2'h0;
logic [13:0] dDat = 14'h0000, pDat = 14'h0000;
wire [13:0] dAddr, pAddr;
wire dVal, pVal;
wire [7:0] dCnt, pCnt;
int fail_count = 0, total_checks = 0;
initial forever #5 clock = ~clock;
oau_operand_address_unit i_oau_operand_address_unit (.clock(clock), .sys_rst(sys_rst), .dmOp(op),
    .dmPtrSel(ptr), .dmModSel(md), .dmLoadTarget(tgt), .dmLoadIndex(idx), .dmLoadData(dDat),
    .dmAddr(dAddr), .dmAddrValid(dVal), .pmOp(pOp), .pmPtrSel(ptr), .pmModSel(md), .pmLoadTarget(tgt),
    .pmLoadIndex(idx), .pmLoadData(pDat), .programMemoryAddressBus(pAddr), .pmAddrValid(pVal));
oau_mem_model i_oau_mem_model_dm (.clock(clock), .valid(dVal), .fetches(dCnt));
oau_mem_model i_oau_mem_model_pm (.clock(clock), .valid(pVal), .fetches(pCnt));
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [13:0] seen, input logic [13:0] want);
    total_checks++;
    if (seen !== want) begin
        fail_count++;
        $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
endtask
// op is left set so that commands can follow back to back
task automatic ld(input logic [1:0] t, input logic [1:0] i, input logic [13:0] dv, pv);
    {op, pOp, tgt, idx, dDat, pDat} = {2'h2, 2'h2, t, i, dv, pv};
    @(posedge clock) #1;
endtask
task automatic acc(input logic [1:0] p, m, input logic [13:0] de, pe);
    {op, pOp, ptr, md} = {2'h1, 2'h1, p, m};
    @(posedge clock) #1;
    check(dAddr, de);
    check(pAddr, pe);
endtask
task automatic idle;
    op = 2'h0;
    pOp = 2'h0;
    @(posedge clock) #1;
endtask
task automatic t_linear;
    ld(2'h0, 2'h0, 14'h0100, 14'h0001);
    ld(2'h1, 2'h1, 14'h0003, 14'h3fff);
    acc(2'h0, 2'h1, 14'h0100, 14'h0001);
    acc(2'h0, 2'h1, 14'h0103, 14'h0000);
    acc(2'h0, 2'h1, 14'h0106, 14'h3fff);
    idle;
endtask
task automatic t_circ;
    ld(2'h0, 2'h1, 14'h0010, 14'h0020);
    ld(2'h2, 2'h1, 14'h0004, 14'h0004);
    ld(2'h1, 2'h2, 14'h0003, 14'h3ffd);
    acc(2'h1, 2'h2, 14'h0010, 14'h0020);
    acc(2'h1, 2'h2, 14'h0013, 14'h0021);
    acc(2'h1, 2'h2, 14'h0012, 14'h0022);
    acc(2'h1, 2'h2, 14'h0011, 14'h0023);
    acc(2'h0, 2'h1, 14'h0109, 14'h3ffe);
    idle;
endtask
// refused op code, one generator alone, then a buffer whose base is not its pointer
task automatic t_misc;
    {op, pOp, tgt, idx, dDat, pDat} = {2'h3, 2'h3, 2'h0, 2'h0, 14'h0aaa, 14'h0bbb};
    @(posedge clock) #1;
    check({12'h000, dVal, pVal}, 14'h0000);
    acc(2'h0, 2'h1, 14'h010c, 14'h3ffd);
    {op, pOp} = {2'h1, 2'h0};
    @(posedge clock) #1;
    check({12'h000, dVal, pVal}, 14'h0002);
    check(dAddr, 14'h010f);
    check(pAddr, 14'h3ffd);
    ld(2'h3, 2'h0, 14'h0110, 14'h3ffa);
    ld(2'h2, 2'h0, 14'h0004, 14'h0004);
    acc(2'h0, 2'h1, 14'h0112, 14'h3ffc);
    acc(2'h0, 2'h1, 14'h0111, 14'h3ffb);
    acc(2'h0, 2'h1, 14'h0110, 14'h3ffa);
    acc(2'h0, 2'h1, 14'h0113, 14'h3ffd);
    idle;
endtask
task automatic t_reset;
    {sys_rst, op, pOp} = {1'b1, 2'h0, 2'h0};
    @(posedge clock) #1;
    check(dAddr, 14'h0000);
    check(pAddr, 14'h0000);
    sys_rst = 1'b0;
    acc(2'h0, 2'h1, 14'h0000, 14'h0000);
    acc(2'h0, 2'h1, 14'h0000, 14'h0000);
    idle;
endtask
task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
initial begin
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    t_linear;
    t_circ;
    t_misc;
    check({6'h00, dCnt}, 14'h000e);
    check({6'h00, pCnt}, 14'h000d);
    t_reset;
    end_of_test;
end
initial begin
    #2000;
    fail_count++;
    end_of_test;
end
endmodule // oau_operand_address_unit_tb_top
`default_nettype wire
